// ---- core/fsil_top.sv ----
`timescale 1ns/1ps
`include "fsil_regs.svh"
module fsil_top #(
    parameter int N_SETUP = `FSIL_SETUP_REG_COUNT
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [31:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire fsil_pkg::fsil_size_t size,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic rd_valid,
    input wire logic sequencer_ready_flag,
    input wire logic lock_read_start,
    input wire logic lock_read_value,
    output logic [N_SETUP-1:0] setup_init_req,
    output logic setup_init_bit,
    output logic lock_state_bit
);
    logic sel_init;
    logic sel_lock;
    logic init_we;
    logic ready_q;
    logic ready_rise;
    fsil_pkg::fsil_cmd_state_t cmd_q;

    assign sel_init = addr == `FSIL_ADDR_SETUP_INIT && size == fsil_pkg::FSIL_SZ_HALF;
    assign sel_lock = addr == `FSIL_ADDR_LOCK_STAT && size == fsil_pkg::FSIL_SZ_BYTE;
    // Key, ready and whole-halfword access all required
    assign init_we = wr_en && sel_init && sequencer_ready_flag
        && wdata[`FSIL_KEY_MSB:`FSIL_KEY_LSB] == `FSIL_SETUP_KEY;

    fsil_bit_reg u_init (
        .mclk(mclk),
        .srst(srst),
        .we(init_we),
        .wd(wdata[`FSIL_INIT_BIT]),
        .q(setup_init_bit)
    );

    // Level request, so set-up registers stay cleared while the bit is one
    generate
        for (genvar i = 0; i < N_SETUP; i++) begin : g_init
            assign setup_init_req[i] = setup_init_bit;
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= sequencer_ready_flag;
        end
    end
    assign ready_rise = sequencer_ready_flag && !ready_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_q <= fsil_pkg::FSIL_IDLE;
        end else begin
            case (cmd_q)
                fsil_pkg::FSIL_IDLE: begin
                    if (lock_read_start) begin
                        cmd_q <= fsil_pkg::FSIL_LOCK_READ;
                    end
                end
                fsil_pkg::FSIL_LOCK_READ: begin
                    if (ready_rise) begin
                        cmd_q <= fsil_pkg::FSIL_IDLE;
                    end
                end
                default: begin
                    cmd_q <= fsil_pkg::FSIL_IDLE;
                end
            endcase
        end
    end

    // Other commands completing must not disturb the captured state
    always_ff @(posedge mclk) begin
        if (srst) begin
            lock_state_bit <= 1'b0;
        end else if (cmd_q == fsil_pkg::FSIL_LOCK_READ && ready_rise) begin
            lock_state_bit <= lock_read_value;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= `FSIL_SETUP_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rdata <= `FSIL_SETUP_RESET;
            if (rd_en && sel_init) begin
                rdata[`FSIL_INIT_BIT] <= setup_init_bit;
            end else if (rd_en && sel_lock) begin
                rdata[`FSIL_LOCK_BIT] <= lock_state_bit;
            end
        end
    end

    init_pulse_a: assert property (@(posedge mclk) disable iff (srst)
        init_we |=> setup_init_bit == $past(wdata[`FSIL_INIT_BIT]))
        else $error("init bit not written");
    init_nokey_a: assert property (@(posedge mclk) disable iff (srst)
        wr_en && sel_init && wdata[`FSIL_KEY_MSB:`FSIL_KEY_LSB] != `FSIL_SETUP_KEY |=> $stable(setup_init_bit))
        else $error("init bit changed without key");
    init_busy_a: assert property (@(posedge mclk) disable iff (srst)
        !sequencer_ready_flag |=> $stable(setup_init_bit))
        else $error("init bit changed while busy");
    init_req_a: assert property (@(posedge mclk) disable iff (srst)
        setup_init_bit |-> &setup_init_req)
        else $error("setup init request missing");
    init_hold_a: assert property (@(posedge mclk) disable iff (srst)
        !setup_init_bit |-> setup_init_req == '0)
        else $error("setup init request spurious");
    key_zero_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en && sel_init |=> rdata[15:1] == 15'h0000)
        else $error("key or reserved bits nonzero");
    lock_load_a: assert property (@(posedge mclk) disable iff (srst)
        cmd_q == fsil_pkg::FSIL_LOCK_READ && ready_rise |=> lock_state_bit == $past(lock_read_value))
        else $error("lock state not loaded");
    lock_hold_a: assert property (@(posedge mclk) disable iff (srst)
        cmd_q == fsil_pkg::FSIL_IDLE |=> $stable(lock_state_bit))
        else $error("lock state changed outside lock read");
    lock_read_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en && sel_lock |=> rdata == {15'h0000, $past(lock_state_bit)})
        else $error("lock status read wrong");

    // Steps of a keyed init write, shared by the properties below
    sequence init_write_s;
        wr_en && sel_init && sequencer_ready_flag && wdata[`FSIL_KEY_MSB:`FSIL_KEY_LSB] == `FSIL_SETUP_KEY;
    endsequence

    sequence init_set_s;
        init_write_s ##0 wdata[`FSIL_INIT_BIT];
    endsequence

    sequence init_clear_s;
        init_write_s ##0 !wdata[`FSIL_INIT_BIT];
    endsequence

    // Steps of a lock-bit read: issue, then ready rising to close it
    sequence lock_issue_s;
        cmd_q == fsil_pkg::FSIL_IDLE && lock_read_start;
    endsequence

    sequence lock_done_s;
        cmd_q == fsil_pkg::FSIL_LOCK_READ && ready_rise;
    endsequence

    sequence lock_wait_s;
        cmd_q == fsil_pkg::FSIL_LOCK_READ && !ready_rise;
    endsequence

    // Reset checks run without a disable so they see the reset cycle itself
    rst_init_a: assert property (@(posedge mclk)
        srst |=> !setup_init_bit)
        else $error("init bit not cleared by reset");

    rst_lock_a: assert property (@(posedge mclk)
        srst |=> !lock_state_bit)
        else $error("lock state not cleared by reset");

    rst_rdata_a: assert property (@(posedge mclk)
        srst |=> rdata == `FSIL_SETUP_RESET && !rd_valid)
        else $error("read port not idle after reset");

    init_set_a: assert property (@(posedge mclk) disable iff (srst)
        init_set_s |=> setup_init_bit && &setup_init_req)
        else $error("keyed set did not request set-up init");

    init_clear_a: assert property (@(posedge mclk) disable iff (srst)
        init_clear_s |=> !setup_init_bit && setup_init_req == '0)
        else $error("keyed clear did not release set-up registers");

    init_size_a: assert property (@(posedge mclk) disable iff (srst)
        wr_en && addr == `FSIL_ADDR_SETUP_INIT && size != fsil_pkg::FSIL_SZ_HALF |=> $stable(setup_init_bit))
        else $error("init bit written by wrong access size");

    init_idle_a: assert property (@(posedge mclk) disable iff (srst)
        !wr_en |=> $stable(setup_init_bit))
        else $error("init bit changed without a write");

    init_read_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en && sel_init |=> rdata[`FSIL_INIT_BIT] == $past(setup_init_bit))
        else $error("init bit read back wrong");

    valid_pulse_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en |=> rd_valid)
        else $error("read valid missing");

    valid_idle_a: assert property (@(posedge mclk) disable iff (srst)
        !rd_en |=> !rd_valid && rdata == `FSIL_SETUP_RESET)
        else $error("read port active without a read");

    lock_size_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en && addr == `FSIL_ADDR_LOCK_STAT && size != fsil_pkg::FSIL_SZ_BYTE |=> rdata == `FSIL_SETUP_RESET)
        else $error("lock status returned on wrong size");

    // Unmapped or wrongly sized reads must not leak either register
    unmapped_zero_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en && !sel_init && !sel_lock |=> rdata == `FSIL_SETUP_RESET)
        else $error("unmapped read nonzero");

    lock_issue_a: assert property (@(posedge mclk) disable iff (srst)
        lock_issue_s |=> cmd_q == fsil_pkg::FSIL_LOCK_READ)
        else $error("lock read not tracked");

    lock_done_a: assert property (@(posedge mclk) disable iff (srst)
        lock_done_s |=> cmd_q == fsil_pkg::FSIL_IDLE)
        else $error("lock read not closed on ready");

    lock_wait_a: assert property (@(posedge mclk) disable iff (srst)
        lock_wait_s |=> $stable(lock_state_bit) && cmd_q == fsil_pkg::FSIL_LOCK_READ)
        else $error("lock state moved before ready rose");

    lock_upper_a: assert property (@(posedge mclk) disable iff (srst)
        rd_en && sel_lock |=> rdata[15:1] == 15'h0000)
        else $error("lock status upper bits nonzero");
endmodule

// ---- core/fsil_regs.svh ----
// Functional notes
// - Set-up initialize register is 16 bits, whole-halfword access, resets to zero.
// - Key bits 15..8 are never stored and always read zero.
// - Init bit write accepted only while sequencer ready flag is one.
// - Init bit changes only when the same write carries key 2D in 15..8.
// - Init bit at one returns all seven set-up registers to initial values.
// - Init bit at zero leaves set-up registers holding their values.
// - Reserved bits 7..1 read their reset value; software writes it back.
// - Lock status register is 8-bit read-only, byte reads, resets to zero.
// - Lock state bit holds until next lock-bit read completes.
// - Lock state bit 0: 0 protected, 1 not protected; bits 7..1 read zero.
`ifndef FSIL_REGS_SVH
`define FSIL_REGS_SVH
`define FSIL_ADDR_SETUP_INIT 32'hFFA1008C
`define FSIL_ADDR_LOCK_STAT 32'hFFA10090
`define FSIL_SETUP_KEY 8'h2D
`define FSIL_KEY_MSB 15
`define FSIL_KEY_LSB 8
`define FSIL_INIT_BIT 0
`define FSIL_LOCK_BIT 0
`define FSIL_SETUP_RESET 16'h0000
`define FSIL_LOCK_RESET 8'h00
`define FSIL_SETUP_REG_COUNT 7
`endif

// ---- core/fsil_pkg.sv ----
package fsil_pkg;
    typedef enum logic [1:0] {
        FSIL_SZ_BYTE,
        FSIL_SZ_HALF,
        FSIL_SZ_WORD
    } fsil_size_t;
    typedef enum logic {
        FSIL_IDLE,
        FSIL_LOCK_READ
    } fsil_cmd_state_t;
endpackage

// ---- core/fsil_bit_reg.sv ----
`timescale 1ns/1ps
`include "fsil_regs.svh"
// Single-bit storage with write strobe; used for the init bit
module fsil_bit_reg (
    input wire logic mclk,
    input wire logic srst,
    input wire logic we,
    input wire logic wd,
    output logic q
);
    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= 1'b0;
        end else if (we) begin
            q <= wd;
        end
    end
endmodule

// ---- verif/fsil_seq_model.sv ----
`timescale 1ns/1ps
// Sequencer stand-in: ready drops for a lock read, then rises with the value
module fsil_seq_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic start,
    input wire logic val,
    output logic rdy = 1'b1,
    output logic lval = 1'b0
);
    logic [2:0] cnt_q = 3'h0;
    always @(posedge mclk) begin
        if (srst) begin
            cnt_q <= 3'h0;
            rdy <= 1'b1;
        end else if (start) begin
            cnt_q <= 3'h4;
            rdy <= 1'b0;
            lval <= ~val;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            rdy <= (cnt_q == 3'h1);
            lval <= (cnt_q == 3'h1) ? val : ~val;
        end else begin
            // Value only valid at the rise; toggle after so stale capture shows
            lval <= ~lval;
        end
    end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`include "fsil_regs.svh"
module tb_top;
    localparam fsil_pkg::fsil_size_t sz_h = fsil_pkg::FSIL_SZ_HALF;
    localparam fsil_pkg::fsil_size_t sz_b = fsil_pkg::FSIL_SZ_BYTE;
    localparam logic [31:0] a_ini = `FSIL_ADDR_SETUP_INIT;
    localparam logic [31:0] a_lck = `FSIL_ADDR_LOCK_STAT;
    typedef struct {logic [15:0] wd; fsil_pkg::fsil_size_t sz; logic ib;} fsil_row_t;
    logic mclk = 0, srst = 1, wr_en = 0, rd_en = 0, lrs = 0, lv = 0, rdy, lrv, sib, lsb, rv;
    logic [31:0] addr = 32'h0;
    fsil_pkg::fsil_size_t size = sz_h;
    logic [15:0] wdata = 16'h0, rdata, d;
    logic [6:0] req;
    int n_mismatch = 0, n_checks = 0;
    fsil_row_t rows[6] = '{'{16'h2D01, sz_h, 1'b1}, '{16'h2C00, sz_h, 1'b1}, '{16'h2D00, sz_b, 1'b1},
        '{16'h2D00, sz_h, 1'b0}, '{16'hFF01, sz_h, 1'b0}, '{16'h2D01, sz_h, 1'b1}};
    always #20 mclk = ~mclk;
    fsil_seq_model fsil_seq_model_i (.mclk(mclk), .srst(srst), .start(lrs), .val(lv), .rdy(rdy), .lval(lrv));
    fsil_top fsil_top_i (.mclk(mclk), .srst(srst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .size(size),
        .wdata(wdata), .rdata(rdata), .rd_valid(rv), .sequencer_ready_flag(rdy), .lock_read_start(lrs),
        .lock_read_value(lrv), .setup_init_req(req), .setup_init_bit(sib), .lock_state_bit(lsb));
    task chk(string n, logic [15:0] s, logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [31:0] a, fsil_pkg::fsil_size_t z, logic [15:0] w);
        @(posedge mclk);
        addr <= a;
        size <= z;
        wdata <= w;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task rd(logic [31:0] a, fsil_pkg::fsil_size_t z);
        @(posedge mclk);
        addr <= a;
        size <= z;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
        chk("rd_valid", {15'h0, rv}, 16'h0001);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        // Whole run is about 80 cycles
        #50000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rd(a_ini, sz_h);
        chk("init_reset", d, 16'h0000);
        rd(a_lck, sz_b);
        chk("lock_reset", d, 16'h0000);
        foreach (rows[i]) begin
            wr(a_ini, rows[i].sz, rows[i].wd);
            rd(a_ini, sz_h);
            chk("init_read", d, {15'h0, rows[i].ib});
            chk("init_req", {9'h0, req}, {9'h0, {7{rows[i].ib}}});
        end
        $display("test rows done");
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk);
            lv <= v[0];
            lrs <= 1'b1;
            @(posedge mclk);
            lrs <= 1'b0;
            wr(a_ini, sz_h, 16'h2D00);
            #1;
            chk("busy_write", {15'h0, sib}, 16'h0001);
            repeat (6) @(posedge mclk);
            rd(a_lck, sz_b);
            chk("lock_read", d, {15'h0, v[0]});
        end
        wr(a_ini, sz_h, 16'h2D00);
        repeat (4) @(posedge mclk);
        #1;
        chk("lock_hold", {15'h0, lsb}, 16'h0001);
        rd(a_lck, sz_h);
        chk("lock_half", d, 16'h0000);
        rd(32'hFFA10094, sz_b);
        chk("unmapped", d, 16'h0000);
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("rst_again", {14'h0, sib, lsb}, 16'h0000);
        $display("test hand cases done");
        finish_test;
    end
endmodule
